// ### src/sdd_map.svh
// Register offsets, field positions and reset values of the sync/pin block
`ifndef SDD_MAP_SVH
`define SDD_MAP_SVH

// Register offsets (4-bit address)
`define SDD_A_OPCTL   4'h0
`define SDD_A_PCFG    4'h1
`define SDD_A_PAT1    4'h2
`define SDD_A_PAT8    4'h9
`define SDD_A_MAP1    4'ha
`define SDD_A_MAP2    4'hb
`define SDD_A_STAT    4'hc

// Field positions of the operation control register
`define SDD_F_MODE    0
`define SDD_F_PKT     3
`define SDD_F_BSYNC   4

// Field positions of pattern_config_reg
`define SDD_F_SYNC_ENABLE  7
`define SDD_F_SIZE    3
`define SDD_F_TOL     0

// Field positions of the status register
`define SDD_F_MATCH   0
`define SDD_F_RXWIN   1
`define SDD_F_TXBIT   2

// Reset values
`define SDD_R_OPCTL   8'h01
`define SDD_R_PCFG    8'h98
`define SDD_R_PAT     8'h01
`define SDD_R_MAP     8'h00

`endif

// ### src/sdd_pkg.sv
// Types shared by the sync/pin block files
package sdd_pkg;

	// Operating modes of the transceiver
	typedef enum logic [2:0] {
		SDD_SLEEP,
		SDD_STDBY,
		SDD_FS,
		SDD_TX,
		SDD_RX
	} sdd_mode_t;

	// Internal signals that a pin may carry
	typedef enum logic [4:0] {
		SRC_LOW, SRC_REF_CLOCK_OUTPUT, SRC_RSSI, SRC_DATA, SRC_DCLK,
		SRC_SYNC, SRC_RXRDY, SRC_TXRDY, SRC_TIMEOUT, SRC_AUTO,
		SRC_MODERDY, SRC_LOCK, SRC_FULL, SRC_NE, SRC_LEVEL,
		SRC_CRC, SRC_PAYLOAD, SRC_SENT
	} sdd_src_t;

	// Status levels from the rest of the radio, same clock
	typedef struct packed {
		logic mode_settled;
		logic auto_sequence_active;
		logic synth_locked;
		logic receiver_ready;
		logic transmitter_ready;
		logic rssi_hit;
		logic timeout_hit;
		logic ref_clock_output;
		logic queue_full;
		logic queue_has_data;
		logic queue_above_threshold;
		logic checksum_pass;
		logic payload_available;
		logic packet_done;
		logic ph_tx_bit;
	} sdd_stat_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sdd_req_t;

endpackage

// ### src/sdd_sync_corr.sv
// Sync pattern correlator: shift register, masked compare, error count
`timescale 1ns/1ps
`default_nettype none
module sdd_sync_corr
	import sdd_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Bit stream
	input  wire logic        en,
	input  wire logic        bit_vld,
	input  wire logic        bit_in,
	// Pattern setup
	input  wire logic [63:0] pattern,
	input  wire logic [2:0]  size,
	input  wire logic [2:0]  tol,
	// Result
	output logic             hit
);
	logic [63:0] shreg_r;   // Newest bit in bit 0
	logic [6:0]  fill_r;    // Bits seen since enable, saturating
	logic [63:0] pat_al;    // Pattern right aligned to its length
	logic [63:0] diff;      // Mismatch per compared bit
	logic [6:0]  nbits;     // Pattern length in bits
	logic [6:0]  errs;      // Mismatch count
	logic        vld_d;     // New bit shifted in last cycle

	assign nbits  = {1'b0, size, 3'h0} + 7'h08;
	// Earliest bit meets bit 7 of the first byte
	assign pat_al = pattern >> (7'h40 - nbits);

	// Per-bit compare, masked to the programmed length
	genvar g;
	generate
		for (g = 0; g < 64; g++) begin : g_cmp
			assign diff[g] = (shreg_r[g] ^ pat_al[g]) & (g < nbits);
		end
	endgenerate

	// Count mismatches
	always_comb begin
		errs = 7'h00;
		for (int i = 0; i < 64; i++) begin
			errs = errs + {6'h00, diff[i]};
		end
	end

	// Shift in each received bit; cleared while disabled
	always_ff @(posedge ref_clk) begin
		if (srst || !en) begin
			shreg_r <= 64'h0;
			fill_r  <= 7'h00;
		end else if (bit_vld) begin
			shreg_r <= {shreg_r[62:0], bit_in};
			if (fill_r != 7'h40) begin
				fill_r <= fill_r + 7'h01;
			end
		end
	end

	// Match once a full pattern is in and errors are tolerable
	always_ff @(posedge ref_clk) begin
		if (srst || !en) begin
			vld_d <= 1'b0;
			hit   <= 1'b0;
		end else begin
			vld_d <= bit_vld;
			// Judged only on a fresh bit: a stale match must not
			// keep setting the flag against its clears
			hit   <= vld_d && (fill_r >= nbits)
				&& (errs <= {4'h0, tol});
		end
	end

	AST_TOL_LIMIT: assert property (@(posedge ref_clk) disable iff (srst)
		hit |-> ($past(errs) <= {4'h0, $past(tol)}))
		else $error("Match declared with too many errors");
	AST_NO_MATCH_OFF: assert property (@(posedge ref_clk) disable iff (srst)
		!$past(en) |-> !hit)
		else $error("Match while recognition disabled");
endmodule
`default_nettype wire

// ### src/sdd_top.sv
// Sync recognition, pin function routing and continuous-mode data path
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sdd_map.svh"
module sdd_top
	import sdd_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// Register port
	input  wire sdd_req_t    req,
	output logic [7:0]       rd_data,
	// Modem and radio status
	input  wire logic        bit_clk_in,
	input  wire logic        demod_raw,
	input  wire sdd_stat_t   stat,
	// Toward modulator and packet handler
	output logic             tx_mod_data,
	output logic             tx_bit_vld,
	output logic             sync_match_flag,
	output logic [63:0]      sync_tx_pattern,
	output logic [2:0]       sync_tx_size,
	// General purpose pins
	output logic             io_pin_0,
	output logic             io_pin_1,
	input  wire logic        io_pin_2_i,
	output logic             io_pin_2_o,
	output logic             io_pin_2_oe,
	output logic             io_pin_3,
	output logic             io_pin_4,
	output logic             io_pin_5
);
	logic [7:0]  opctl_r;          // Mode, data mode, synchronizer
	logic [7:0]  pattern_config_reg;
	logic [63:0] pat_r;            // sync_pattern_value
	logic [7:0]  pin_function_map_1;
	logic [7:0]  pin_function_map_2;
	logic [7:0]  rd_data_r;
	sdd_mode_t   mode;
	logic        pkt;              // Packet data mode
	logic        bsync;            // Synchronizer enable in continuous
	logic        is_rx;
	logic        is_tx;
	logic [11:0] codes;            // Two bits per pin, pin 0 lowest
	logic        sync_enable;
	logic        corr_en;
	logic        corr_hit;
	logic        flag_r;

	// Field pick-apart
	assign mode  = sdd_mode_t'(opctl_r[`SDD_F_MODE +: 3]);
	assign pkt   = opctl_r[`SDD_F_PKT];
	assign bsync = opctl_r[`SDD_F_BSYNC];
	assign is_rx = (mode == SDD_RX);
	assign is_tx = (mode == SDD_TX);
	assign sync_enable = pattern_config_reg[`SDD_F_SYNC_ENABLE];
	assign codes = {pin_function_map_2[5:4], pin_function_map_2[7:6],
		pin_function_map_1[1:0], pin_function_map_1[3:2],
		pin_function_map_1[5:4], pin_function_map_1[7:6]};

	// Register writes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			opctl_r            <= `SDD_R_OPCTL;
			pattern_config_reg <= `SDD_R_PCFG;
			pat_r              <= {8{`SDD_R_PAT}};
			pin_function_map_1 <= `SDD_R_MAP;
			pin_function_map_2 <= `SDD_R_MAP;
		end else if (req.wr) begin
			case (req.addr)
				`SDD_A_OPCTL: opctl_r <= req.wdata;
				`SDD_A_PCFG: pattern_config_reg <= req.wdata;
				`SDD_A_MAP1: pin_function_map_1 <= req.wdata;
				`SDD_A_MAP2: pin_function_map_2 <= req.wdata;
				default: begin
					// Byte n of the pattern, first byte on top
					if (req.addr >= `SDD_A_PAT1 && req.addr <= `SDD_A_PAT8) begin
						pat_r[8*(4'h9 - req.addr) +: 8] <= req.wdata;
					end
				end
			endcase
		end
	end

	// Pattern and length go to the transmit packet builder too
	assign sync_tx_pattern = pat_r;
	assign sync_tx_size    = pattern_config_reg[`SDD_F_SIZE +: 3];

	// Link clock and pin input synchronisers
	logic bclk_m, bclk_s, bclk_d;
	logic raw_m, raw_s;
	logic d2_m, d2_s;
	logic bclk_rise, bclk_fall;

	// Two flops each, plus a third on the bit clock for edge detect; the first stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			{bclk_m, bclk_s, bclk_d} <= 3'h0;
			{raw_m, raw_s}           <= 2'h0;
			{d2_m, d2_s}             <= 2'h0;
		end else begin
			bclk_m <= bit_clk_in;
			bclk_s <= bclk_m;
			bclk_d <= bclk_s;
			raw_m  <= demod_raw;
			raw_s  <= raw_m;
			d2_m   <= io_pin_2_i;
			d2_s   <= d2_m;
		end
	end

	assign bclk_rise = bclk_s & ~bclk_d;
	assign bclk_fall = ~bclk_s & bclk_d;

	// Recognition runs in receive, needs synchronizer unless packet mode
	assign corr_en = sync_enable && is_rx && (pkt || bsync);

	sdd_sync_corr u_corr (
		.ref_clk (ref_clk),
		.srst    (srst),
		.en      (corr_en),
		.bit_vld (bclk_rise),
		.bit_in  (raw_s),
		.pattern (pat_r),
		.size    (pattern_config_reg[`SDD_F_SIZE +: 3]),
		.tol     (pattern_config_reg[`SDD_F_TOL +: 3]),
		.hit     (corr_hit)
	);

	// Queue emptied is the fall of its has-data level
	logic qne_d;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			qne_d <= 1'b0;
		end else begin
			qne_d <= stat.queue_has_data;
		end
	end

	// Match flag: a hit wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			flag_r <= 1'b0;
		end else if (corr_hit) begin
			flag_r <= 1'b1;
		end else if (!is_rx || (qne_d && !stat.queue_has_data)) begin
			flag_r <= 1'b0;
		end
	end
	assign sync_match_flag = flag_r;

	// Packet receive data window between ready and payload rises
	logic rdy_d, pay_d, win_r;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdy_d <= 1'b0;
			pay_d <= 1'b0;
			win_r <= 1'b0;
		end else begin
			rdy_d <= stat.receiver_ready;
			pay_d <= stat.payload_available;
			if (stat.payload_available && !pay_d) begin
				win_r <= 1'b0;
			end else if (stat.receiver_ready && !rdy_d) begin
				win_r <= 1'b1;
			end
		end
	end

	// Cleaned receive bit, changed only on the clock's falling edge
	logic clean_r;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			clean_r <= 1'b0;
		end else if (bclk_fall) begin
			clean_r <= raw_s;
		end
	end

	// Continuous transmit: data pin taken at the bit clock rise
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_mod_data <= 1'b0;
			tx_bit_vld  <= 1'b0;
		end else begin
			tx_bit_vld <= !pkt && is_tx && bclk_rise;
			if (!pkt && is_tx && bclk_rise) begin
				tx_mod_data <= d2_s;
			end
		end
	end

	// Function chosen for one pin from its code, mode and data mode
	function automatic sdd_src_t pin_src(input int pin, input logic [1:0] c,
			input sdd_mode_t m, input logic p);
		logic rx, tx, fs, sl;
		sdd_src_t s;
		rx = (m == SDD_RX);
		tx = (m == SDD_TX);
		fs = (m == SDD_FS);
		sl = (m == SDD_SLEEP);
		s  = SRC_LOW;
		case (pin)
			0: begin
				if (p) begin
					case (c)
						2'h0: s = rx ? SRC_CRC : tx ? SRC_SENT : SRC_LOW;
						2'h1: s = rx ? SRC_PAYLOAD : tx ? SRC_TXRDY : SRC_LOW;
						2'h2: s = rx ? SRC_SYNC : SRC_LOW;
						default: s = rx ? SRC_RSSI : (fs | tx) ? SRC_LOCK : SRC_LOW;
					endcase
				end else begin
					case (c)
						2'h0: s = rx ? SRC_SYNC : (fs | tx) ? SRC_LOCK : SRC_LOW;
						2'h1: s = rx ? SRC_TIMEOUT : tx ? SRC_TXRDY : SRC_LOW;
						2'h2: s = rx ? SRC_RSSI : SRC_LOW;
						default: s = SRC_MODERDY;
					endcase
				end
			end
			1: begin
				if (p) begin
					case (c)
						2'h0: s = SRC_LEVEL;
						2'h1: s = SRC_FULL;
						2'h2: s = SRC_NE;
						default: s = rx ? SRC_TIMEOUT : (fs | tx) ? SRC_LOCK : SRC_LOW;
					endcase
				end else begin
					case (c)
						2'h0: s = (rx | tx) ? SRC_DCLK : SRC_LOW;
						2'h1: s = rx ? SRC_RXRDY : tx ? SRC_TXRDY : SRC_LOW;
						2'h2: s = SRC_LOW;
						default: s = rx ? SRC_SYNC : (fs | tx) ? SRC_LOCK : SRC_LOW;
					endcase
				end
			end
			2: begin
				if (p) begin
					case (c)
						2'h0: s = SRC_NE;
						2'h1: s = (rx | tx) ? SRC_DATA : SRC_LOW;
						2'h2: s = SRC_LOW;
						default: s = SRC_AUTO;
					endcase
				end else begin
					s = (rx | tx) ? SRC_DATA : SRC_LOW;
				end
			end
			3: begin
				if (p) begin
					case (c)
						2'h0: s = SRC_FULL;
						2'h1: s = rx ? SRC_RSSI : tx ? SRC_TXRDY : SRC_LOW;
						2'h2: s = rx ? SRC_SYNC : SRC_LOW;
						default: s = (fs | rx | tx) ? SRC_LOCK : SRC_LOW;
					endcase
				end else begin
					case (c)
						2'h0: s = rx ? SRC_RSSI : tx ? SRC_TXRDY : SRC_LOW;
						2'h1: s = rx ? SRC_RXRDY : tx ? SRC_TXRDY : SRC_LOW;
						2'h2: s = SRC_AUTO;
						default: s = rx ? SRC_TIMEOUT : tx ? SRC_TXRDY : SRC_LOW;
					endcase
				end
			end
			5: begin
				case (c)
					2'h0: s = sl ? SRC_LOW : SRC_REF_CLOCK_OUTPUT;
					2'h1: s = p ? ((rx | tx) ? SRC_DATA : SRC_LOW)
						: rx ? SRC_RSSI : tx ? SRC_REF_CLOCK_OUTPUT : SRC_LOW;
					2'h2: s = SRC_LOW;
					default: s = SRC_MODERDY;
				endcase
			end
			default: s = SRC_LOW;
		endcase
		return s;
	endfunction

	// Level of the data signal for the present data mode
	logic data_lvl;
	logic dclk_lvl;
	always_comb begin
		if (pkt) begin
			data_lvl = is_tx ? stat.ph_tx_bit : (win_r & clean_r);
		end else begin
			data_lvl = bsync ? clean_r : raw_s;
		end
		// No clock in receive without the synchronizer
		dclk_lvl = (is_rx && !bsync) ? 1'b0 : bclk_s;
	end

	// Per-pin selection and output flop; each pin decodes alone
	logic [5:0] pin_q;
	genvar p;
	generate
		for (p = 0; p < 6; p++) begin : g_pin
			sdd_src_t src;
			assign src = pin_src(p, codes[2*p +: 2], mode, pkt);
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					pin_q[p] <= 1'b0;
				end else begin
					case (src)
						SRC_REF_CLOCK_OUTPUT:  pin_q[p] <= stat.ref_clock_output;
						SRC_RSSI:    pin_q[p] <= stat.rssi_hit;
						SRC_DATA:    pin_q[p] <= data_lvl;
						SRC_DCLK:    pin_q[p] <= dclk_lvl;
						SRC_SYNC:    pin_q[p] <= flag_r;
						SRC_RXRDY:   pin_q[p] <= stat.receiver_ready;
						SRC_TXRDY:   pin_q[p] <= stat.transmitter_ready;
						SRC_TIMEOUT: pin_q[p] <= stat.timeout_hit;
						SRC_AUTO:    pin_q[p] <= stat.auto_sequence_active;
						SRC_MODERDY: pin_q[p] <= stat.mode_settled;
						SRC_LOCK:    pin_q[p] <= stat.synth_locked;
						SRC_FULL:    pin_q[p] <= stat.queue_full;
						SRC_NE:      pin_q[p] <= stat.queue_has_data;
						SRC_LEVEL:   pin_q[p] <= stat.queue_above_threshold;
						SRC_CRC:     pin_q[p] <= stat.checksum_pass;
						SRC_PAYLOAD: pin_q[p] <= stat.payload_available;
						SRC_SENT:    pin_q[p] <= stat.packet_done;
						default:     pin_q[p] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate

	// Data pin turns to input during continuous transmit
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			io_pin_2_oe <= 1'b0;
		end else begin
			io_pin_2_oe <= !(!pkt && is_tx);
		end
	end

	assign io_pin_0   = pin_q[0];
	assign io_pin_1   = pin_q[1];
	assign io_pin_2_o = pin_q[2];
	assign io_pin_3   = pin_q[3];
	assign io_pin_4   = pin_q[4];
	assign io_pin_5   = pin_q[5];

	// Read data in the cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (srst || !req.rd) begin
			rd_data_r <= 8'h00;
		end else begin
			case (req.addr)
				`SDD_A_OPCTL: rd_data_r <= opctl_r;
				`SDD_A_PCFG: rd_data_r <= pattern_config_reg;
				`SDD_A_MAP1: rd_data_r <= pin_function_map_1;
				`SDD_A_MAP2: rd_data_r <= pin_function_map_2;
				`SDD_A_STAT: rd_data_r <= {5'h00, tx_mod_data, win_r, flag_r};
				default: begin
					if (req.addr >= `SDD_A_PAT1 && req.addr <= `SDD_A_PAT8) begin
						rd_data_r <= pat_r[8*(4'h9 - req.addr) +: 8];
					end else begin
						rd_data_r <= 8'h00;
					end
				end
			endcase
		end
	end
	assign rd_data = rd_data_r;

	AST_CONT_NEEDS_BSYNC: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(flag_r) |-> $past(pkt || bsync, 2))
		else $error("Match in continuous mode without synchronizer");
	AST_CLEAR_OUT_RX: assert property (@(posedge ref_clk) disable iff (srst)
		(!is_rx)[*3] |=> !flag_r)
		else $error("Match flag kept outside receive");
	AST_PKT_FULL_PIN: assert property (@(posedge ref_clk) disable iff (srst)
		(pkt && codes[7:6] == 2'h0) |=> io_pin_3 == $past(stat.queue_full))
		else $error("Queue full not routed to pin 3");
	AST_CONT_TX_IN: assert property (@(posedge ref_clk) disable iff (srst)
		(!pkt && is_tx) |=> !io_pin_2_oe)
		else $error("Data pin driven during continuous transmit");
	AST_TX_SAMPLE: assert property (@(posedge ref_clk) disable iff (srst)
		(!pkt && is_tx && bclk_rise) |=> tx_bit_vld && tx_mod_data == $past(d2_s))
		else $error("Transmit bit not taken at clock rise");
	AST_RAW_NO_CLK: assert property (@(posedge ref_clk) disable iff (srst)
		(!pkt && is_rx && !bsync && codes[3:2] == 2'h0)
		|=> !io_pin_1 && io_pin_2_o == $past(raw_s))
		else $error("Raw receive path wrong");
	AST_FALL_ONLY: assert property (@(posedge ref_clk) disable iff (srst)
		!$past(bclk_fall) |-> $stable(clean_r))
		else $error("Clean data moved off the falling edge");
	AST_WIN_GATE: assert property (@(posedge ref_clk) disable iff (srst)
		(pkt && is_rx && !win_r && codes[5:4] == 2'h1) |=> !io_pin_2_o)
		else $error("Data shown outside receive window");
	AST_UNUSED_LOW: assert property (@(posedge ref_clk) disable iff (srst)
		(codes[11:10] == 2'h2) |=> !io_pin_5)
		else $error("Unassigned code not low");
endmodule
`default_nettype wire

// ### tb/sdd_mcu_model.sv
// Controller model driving the data pin in continuous transmit
`timescale 1ns/1ps
`default_nettype none
module sdd_mcu_model (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic srst,
	// Pins seen by the controller
	input  wire logic dclk,
	input  wire logic rel,
	// Next random bit and notes to the bench
	input  wire logic next_bit,
	output logic      mcu_data,
	output logic      note_stb,
	output logic      note_bit
);
	logic dclk_d; // Clock level one cycle ago
	// Note the held bit at each rise, then change just after it,
	// so the change sits far from both sampling edges
	always_ff @(posedge ref_clk) begin
		dclk_d   <= dclk;
		note_stb <= dclk & ~dclk_d & rel & ~srst;
		note_bit <= mcu_data;
		if (srst)
			mcu_data <= 1'b0;
		else if (note_stb)
			mcu_data <= next_bit;
	end
endmodule
`default_nettype wire

// ### tb/sdd_top_bench.sv
// Bench for sync recognition, pin routing and continuous data
`timescale 1ns/1ps
`default_nettype none
`include "sdd_map.svh"
module sdd_top_bench import sdd_pkg::*; ;
	logic        ref_clk    = 1'b0;     // 10 MHz
	logic        srst       = 1'b1;
	sdd_req_t    req        = '0;
	logic        bit_clk_in = 1'b0;     // Stands still between bits
	logic        demod_raw  = 1'b0;
	sdd_stat_t   stat       = '0;
	logic [31:0] seed       = 32'hde92; // Random source
	logic        rd_seen    = 1'b0;
	logic        bs, ck_ex, dat_on, pb; // Bit task settings
	logic [7:0]  rd_data;
	logic [63:0] sync_tx_pattern;
	logic [2:0]  sync_tx_size;
	logic        tx_mod_data, tx_bit_vld, sync_match_flag;
	logic        io_pin_0, io_pin_1, io_pin_2_o, io_pin_2_oe;
	logic        io_pin_3, io_pin_4, io_pin_5;
	logic        mcu_data, note_stb, note_bit;
	logic [15:0] rd_q[$];               // Mask and value per read
	logic        tx_q[$];               // Bits the controller held
	int          n_errors    = 0;
	int          comparisons = 0;
	// Shared data pin: whoever is enabled sets the level
	wire logic pin2 = io_pin_2_oe ? io_pin_2_o : mcu_data;

	sdd_top sdd_top_i (.ref_clk, .srst, .req, .rd_data, .bit_clk_in,
		.demod_raw, .stat, .tx_mod_data, .tx_bit_vld, .sync_match_flag,
		.sync_tx_pattern, .sync_tx_size, .io_pin_0, .io_pin_1,
		.io_pin_2_i(pin2), .io_pin_2_o, .io_pin_2_oe, .io_pin_3,
		.io_pin_4, .io_pin_5);
	sdd_mcu_model sdd_mcu_model_i (.ref_clk, .srst, .dclk(io_pin_1),
		.rel(~io_pin_2_oe), .next_bit(seed[0]), .mcu_data, .note_stb,
		.note_bit);

	always #50 ref_clk = ~ref_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected pins {5,4,3,2,1,0} per routing case
	function automatic logic [5:0] pins(input int c, input sdd_stat_t s);
		logic [5:0] q;
		q = {s.ref_clock_output, 1'b0, s.queue_full, s.queue_has_data,
			s.queue_above_threshold, s.checksum_pass};
		case (c)
			1: q[0] = s.packet_done;
			2: q[0] = s.payload_available;
			3: q = 6'h00;
			4: q = {s.ref_clock_output, 1'b0, s.transmitter_ready, 2'b00,
				s.synth_locked};
			default: ;
		endcase
		return q;
	endfunction
	task automatic check(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req <= '0;
	endtask
	// Read: note mask and value, the monitor compares
	task automatic rd(input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		rd_q.push_back({m, e});
		@(posedge ref_clk);
		req <= '0;
	endtask
	// One 800 ns bit: data set while the clock is low
	task automatic bit_out(input logic b);
		@(posedge ref_clk);
		demod_raw <= b;
		repeat (2) @(posedge ref_clk);
		bit_clk_in <= 1'b1;
		repeat (4) @(posedge ref_clk);
		if (dat_on)
			check("io_pin_2_o", bs ? pb : b, io_pin_2_o);
		bit_clk_in <= 1'b0;
		@(posedge ref_clk);
		check("io_pin_1", ck_ex, io_pin_1);
	endtask
	// Fresh enable, 16 bits, then flag and status bit
	task automatic run_sync(input logic [7:0] op, cfg,
		input logic [15:0] w, input logic ex, ck);
		wr(`SDD_A_OPCTL, 8'h01);
		wr(`SDD_A_PCFG, 8'h00);
		wr(`SDD_A_OPCTL, op);
		wr(`SDD_A_PCFG, cfg);
		bs = op[4];
		ck_ex = ck;
		dat_on = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			bit_out(w[i]);
			dat_on = ~op[3];
			pb = w[i];
		end
		repeat (6) @(posedge ref_clk);
		check("sync_match_flag", ex, sync_match_flag);
		check("io_pin_2_oe", 1'b1, io_pin_2_oe);
		rd(`SDD_A_STAT, 8'h01, {7'h00, ex});
	endtask

	// Read monitor and controller notes
	always @(posedge ref_clk) begin : mon
		logic [15:0] n;
		if (rd_seen) begin
			n = rd_q.pop_front();
			check("rd_data", n[7:0], rd_data & n[15:8]);
		end
		rd_seen <= req.rd;
		if (note_stb) begin
			tx_q.push_back(note_bit);
			seed <= lfsr(seed);
		end
	end
	// Each transmit bit against the controller's note
	initial forever begin : txmon
		logic v;
		@(posedge ref_clk);
		if (tx_bit_vld === 1'b1) begin
			v = tx_mod_data;
			repeat (3) @(posedge ref_clk);
			check("tx_mod_data", tx_q.pop_front(), v);
		end
	end
	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		rd(`SDD_A_OPCTL, 8'hff, `SDD_R_OPCTL);
		rd(`SDD_A_PCFG, 8'hff, `SDD_R_PCFG);
		for (int a = 2; a < 10; a++)
			rd(4'(a), 8'hff, `SDD_R_PAT);
		rd(`SDD_A_MAP1, 8'hff, `SDD_R_MAP);
		rd(`SDD_A_MAP2, 8'hff, `SDD_R_MAP);
		wr(4'he, 8'h5a);
		rd(4'he, 8'hff, 8'h00);
		// First two pattern bytes only; the other six keep their reset value
		wr(`SDD_A_PAT1, 8'ha5);
		wr(`SDD_A_PAT1 + 4'h1, 8'h3c);
		run_sync(8'h14, 8'h88, 16'ha53c, 1'b1, 1'b1);
		run_sync(8'h14, 8'h88, 16'ha53d, 1'b0, 1'b1);
		run_sync(8'h14, 8'h89, 16'ha53d, 1'b1, 1'b1);
		run_sync(8'h14, 8'h8f, 16'ha5c3, 1'b0, 1'b1);
		run_sync(8'h14, 8'h08, 16'ha53c, 1'b0, 1'b1);
		run_sync(8'h04, 8'h88, 16'ha53c, 1'b0, 1'b0);
		run_sync(8'h0c, 8'h88, 16'ha53c, 1'b1, 1'b0);
		run_sync(8'h14, 8'h80, 16'h00a5, 1'b1, 1'b1);
		run_sync(8'h14, 8'h88, 16'h3ca5, 1'b0, 1'b1);
		// Flag drops when the queue empties, then on leaving receive
		run_sync(8'h14, 8'h88, 16'ha53c, 1'b1, 1'b1);
		stat.queue_has_data <= 1'b1;
		repeat (3) @(posedge ref_clk);
		stat.queue_has_data <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("flag_empty", 1'b0, sync_match_flag);
		run_sync(8'h14, 8'h88, 16'ha53c, 1'b1, 1'b1);
		wr(`SDD_A_OPCTL, 8'h03);
		repeat (3) @(posedge ref_clk);
		check("flag_mode", 1'b0, sync_match_flag);
		check("pattern", {16'ha53c, {6{8'h01}}}, sync_tx_pattern);
		check("size", 3'h1, sync_tx_size);
		// Pin routing with random status levels
		for (int c = 0; c < 5; c++) begin
			wr(`SDD_A_OPCTL, c == 1 ? 8'h0b : c == 3 ? 8'h00 :
				c == 4 ? 8'h03 : 8'h0c);
			wr(`SDD_A_MAP1, c == 2 ? 8'h40 : 8'h00);
			repeat (3) begin
				@(posedge ref_clk);
				stat <= seed[14:0];
				seed <= lfsr(seed);
				repeat (3) @(posedge ref_clk);
				check("pins", pins(c, stat) & (c > 2 ? 6'h3b : 6'h3f),
					{io_pin_5, io_pin_4, io_pin_3, io_pin_2_o, io_pin_1,
					io_pin_0} & (c > 2 ? 6'h3b : 6'h3f));
			end
		end
		// Continuous transmit paced by the bit clock
		stat <= '0;
		repeat (4) @(posedge ref_clk);
		check("io_pin_2_oe", 1'b0, io_pin_2_oe);
		ck_ex = 1'b1;
		dat_on = 1'b0;
		repeat (12) bit_out(1'b0);
		repeat (12) @(posedge ref_clk);
		check("tx_left", 64'h0, 64'(tx_q.size()));
		summarize();
	end
endmodule
`default_nettype wire
